/* hdl/qflash_defs.vh */
// constants for the quad read / wrap / sector clear command block
// assumes a single 125 MHz core clock and a host-driven serial clock
`ifndef QFLASH_DEFS_VH
`define QFLASH_DEFS_VH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define OP_QUAD_READ 8'heb
`define OP_WRITE_UNLOCK 8'h06
`define OP_SECTOR_CLEAR 8'h20
`define OP_SET_BURST 8'hc0

// ----------------------------------------------------------------
// frame lengths in serial clocks
// ----------------------------------------------------------------
`define OPCODE_BITS 5'h08
`define ADDR_NIBBLES 5'h06
`define MODE_CYCLES 5'h02
`define DUMMY_CYCLES 5'h04
`define SERIAL_ADDR_BITS 5'h18
`define WRAP_CODE_BITS 5'h08

// ----------------------------------------------------------------
// array layout and wrap codes
// ----------------------------------------------------------------
`define ARRAY_ADDR_BITS 20
`define SECTOR_LSB 12
`define BLOCK_LSB 16
`define WRAP_CODE_8 8'h00
`define WRAP_CODE_64 8'h03
`define WRAP_OFF_NIBBLE 4'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define SECTOR_CLEAR_TIME_US 1000
`define SECTOR_CLEAR_CYCLES (`SECTOR_CLEAR_TIME_US * 1000 / `CLK_PERIOD_NS)

`endif

/* hdl/pin_sync.v */
// two-stage synchroniser for a group of pin inputs
// assumes inputs are asynchronous to i_clk; only stage two is read outside
`timescale 1ns/10ps
module pin_sync #(
    parameter WIDTH = 6,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire i_clk,
    input wire i_rst,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    // ------------------------------------------------------------
    // per-bit flop pair
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            // stage one feeds stage two only, to keep metastability contained
            always @(posedge i_clk) begin
                if (i_rst) begin
                    meta_q <= RST_VAL[g];
                    sync_q <= RST_VAL[g];
                end else begin
                    meta_q <= i_async[g];
                    sync_q <= meta_q;
                end
            end
            assign o_sync[g] = sync_q;
        end
    endgenerate

endmodule

/* hdl/clear_timer.v */
// self-timed cycle counter for the sector clear operation
// assumes i_start is a one-cycle pulse and is not repeated while busy
`timescale 1ns/10ps
module clear_timer #(
    parameter CYCLES = 125000
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_start,
    output reg o_done
);

    reg [31:0] cnt_q;
    reg run_q;

    // ------------------------------------------------------------
    // countdown; done pulses once when the count runs out
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= 32'h0000_0000;
            run_q <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !run_q) begin
                cnt_q <= CYCLES - 1;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q == 32'h0000_0000) begin
                    run_q <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 32'h0000_0001;
                end
            end
        end
    end

endmodule

/* hdl/qflash_cmd.v */
// serial flash command sequencer: quad i/o read with continuous-read
// (enhance) mode, burst wrap setup, write unlock and 4 KB sector clear
// assumes host drives chip select and serial clock far slower than i_clk;
// the array sits outside and returns i_rd_data for o_rd_addr within a
// few core clocks
`timescale 1ns/10ps
`include "qflash_defs.vh"

module qflash_cmd #(
    parameter ADDR_BITS = `ARRAY_ADDR_BITS,
    parameter CLEAR_CYCLES = `SECTOR_CLEAR_CYCLES
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_chip_select_n,
    input wire i_serial_clock,
    input wire [3:0] i_io_lines,
    output reg [3:0] o_io_lines,
    output reg [3:0] o_io_lines_oe_n,
    input wire i_quad_enable_bit,
    input wire [3:0] i_block_protect_bits,
    output reg [ADDR_BITS-1:0] o_rd_addr,
    input wire [7:0] i_rd_data,
    output reg o_clear_start,
    output reg [ADDR_BITS-`SECTOR_LSB-1:0] o_clear_sector,
    output reg o_write_in_progress,
    output reg o_write_enable_latch,
    output reg o_enhance_mode,
    output reg o_wrap_enabled
);

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_CMD = 3'h1;
    localparam [2:0] ST_ADDR = 3'h2;
    localparam [2:0] ST_MODE = 3'h3;
    localparam [2:0] ST_DUMMY = 3'h4;
    localparam [2:0] ST_DATA = 3'h5;
    localparam [2:0] ST_SERIAL = 3'h6;
    localparam [2:0] ST_IGNORE = 3'h7;

    // ------------------------------------------------------------
    // pin sampling and edge finding
    // ------------------------------------------------------------
    wire [5:0] pins_s;
    wire cs_n_s = pins_s[5];
    wire sclk_s = pins_s[4];
    wire [3:0] io_s = pins_s[3:0];
    reg cs_n_d_q;
    reg sclk_d_q;

    pin_sync #(
        .WIDTH(6),
        .RST_VAL(6'h20)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_chip_select_n, i_serial_clock, i_io_lines}),
        .o_sync(pins_s)
    );

    // edge detect runs on stage-two outputs only
    always @(posedge i_clk) begin
        if (i_rst) begin
            cs_n_d_q <= 1'b1;
            sclk_d_q <= 1'b0;
        end else begin
            cs_n_d_q <= cs_n_s;
            sclk_d_q <= sclk_s;
        end
    end

    wire cs_fall = cs_n_d_q & ~cs_n_s;
    wire cs_rise = ~cs_n_d_q & cs_n_s;
    wire sclk_rise = ~cs_n_s & sclk_s & ~sclk_d_q;
    wire sclk_fall = ~cs_n_s & ~sclk_s & sclk_d_q;

    // ------------------------------------------------------------
    // self-timed clear cycle
    // ------------------------------------------------------------
    wire clear_done;

    clear_timer #(
        .CYCLES(CLEAR_CYCLES)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(o_clear_start),
        .o_done(clear_done)
    );

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    reg [2:0] state_q;
    reg [4:0] cnt_q;
    reg [7:0] op_q;
    reg [23:0] shift_q;
    reg [7:0] mode_q;
    reg nib_hi_q;
    reg [1:0] wrap_sel_q;

    // low-address mask of the wrap window, 8 to 64 bytes
    wire [5:0] wrap_mask = {wrap_sel_q == 2'h3, wrap_sel_q >= 2'h2, wrap_sel_q != 2'h0, 3'h7};
    wire [5:0] low_inc = o_rd_addr[5:0] + 6'h01;
    wire [ADDR_BITS-1:0] addr_inc = o_rd_addr + {{(ADDR_BITS-1){1'b0}}, 1'b1};
    wire [ADDR_BITS-1:0] addr_wrap = {o_rd_addr[ADDR_BITS-1:6],
        (o_rd_addr[5:0] & ~wrap_mask) | (low_inc & wrap_mask)};
    // plain increment wraps through zero at the top of the array
    wire [ADDR_BITS-1:0] addr_next = o_wrap_enabled ? addr_wrap : addr_inc;

    // mode byte toggles when each upper bit differs from its lower twin
    wire mode_toggles = &(mode_q[7:4] ^ mode_q[3:0]);

    // sector protection: top 2^(bp-1) 64 KB blocks, all of them from bp=5
    wire [3:0] blk_idx = shift_q[ADDR_BITS-1 -: 4];
    wire [4:0] prot_span = (i_block_protect_bits == 4'h0) ? 5'h00 :
        (i_block_protect_bits >= 4'h5) ? 5'h10 :
        (5'h01 << (i_block_protect_bits - 4'h1));
    wire sector_protected = ({1'b0, blk_idx} >= (5'h10 - prot_span)) && (prot_span != 5'h00);

    // ------------------------------------------------------------
    // command state machine
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            op_q <= 8'h00;
            shift_q <= 24'h000000;
            mode_q <= 8'hff;
            nib_hi_q <= 1'b1;
            wrap_sel_q <= 2'h0;
            o_wrap_enabled <= 1'b0;
            o_enhance_mode <= 1'b0;
            o_rd_addr <= {ADDR_BITS{1'b0}};
            o_io_lines <= 4'h0;
            o_io_lines_oe_n <= 4'hf;
            o_clear_start <= 1'b0;
            o_clear_sector <= {(ADDR_BITS-`SECTOR_LSB){1'b0}};
            o_write_in_progress <= 1'b0;
            o_write_enable_latch <= 1'b0;
        end else begin
            o_clear_start <= 1'b0;
            // clear cycle ends: busy drops and the unlock latch resets
            if (clear_done) begin
                o_write_in_progress <= 1'b0;
                o_write_enable_latch <= 1'b0;
            end
            if (cs_n_s) begin
                o_io_lines_oe_n <= 4'hf; // release the lines whenever deselected
            end
            if (cs_rise) begin
                state_q <= ST_IDLE;
                // frame-end actions need the exact bit count
                if (op_q == `OP_WRITE_UNLOCK && state_q == ST_IGNORE
                        && cnt_q == `OPCODE_BITS && !o_write_in_progress) begin
                    o_write_enable_latch <= 1'b1;
                end
                if (op_q == `OP_SECTOR_CLEAR && state_q == ST_SERIAL
                        && cnt_q == `SERIAL_ADDR_BITS && o_write_enable_latch
                        && !o_write_in_progress) begin
                    if (sector_protected) begin
                        o_write_enable_latch <= 1'b0;
                    end else begin
                        o_clear_start <= 1'b1;
                        o_clear_sector <= shift_q[ADDR_BITS-1:`SECTOR_LSB];
                        o_write_in_progress <= 1'b1;
                    end
                end
                if (op_q == `OP_SET_BURST && state_q == ST_SERIAL
                        && cnt_q == `WRAP_CODE_BITS) begin
                    if (shift_q[7:4] == `WRAP_OFF_NIBBLE) begin
                        o_wrap_enabled <= 1'b0;
                    end else if (shift_q[7:0] <= `WRAP_CODE_64) begin
                        o_wrap_enabled <= 1'b1;
                        wrap_sel_q <= shift_q[1:0];
                    end
                end
            end else if (cs_fall) begin
                cnt_q <= 5'h00;
                shift_q <= 24'h000000;
                nib_hi_q <= 1'b1;
                if (o_enhance_mode) begin
                    // continuous read: this frame opens with the address
                    op_q <= `OP_QUAD_READ;
                    state_q <= o_write_in_progress ? ST_IGNORE : ST_ADDR;
                end else begin
                    op_q <= 8'h00;
                    state_q <= ST_CMD;
                end
            end else begin
                case (state_q)
                    ST_CMD: begin
                        if (sclk_rise) begin
                            op_q <= {op_q[6:0], io_s[0]};
                            cnt_q <= cnt_q + 5'h01;
                            if (cnt_q == `OPCODE_BITS - 5'h01) begin
                                cnt_q <= 5'h00;
                                case ({op_q[6:0], io_s[0]})
                                    `OP_QUAD_READ: begin
                                        // four-line read needs quad enable, idle array
                                        if (i_quad_enable_bit && !o_write_in_progress) begin
                                            state_q <= ST_ADDR;
                                        end else begin
                                            state_q <= ST_IGNORE;
                                        end
                                    end
                                    `OP_SECTOR_CLEAR: state_q <= ST_SERIAL;
                                    `OP_SET_BURST: state_q <= ST_SERIAL;
                                    default: begin
                                        // unlock is counted on to judge its byte boundary
                                        state_q <= ST_IGNORE;
                                        cnt_q <= `OPCODE_BITS;
                                    end
                                endcase
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (sclk_rise) begin
                            shift_q <= {shift_q[19:0], io_s};
                            cnt_q <= cnt_q + 5'h01;
                            if (cnt_q == `ADDR_NIBBLES - 5'h01) begin
                                cnt_q <= 5'h00;
                                state_q <= ST_MODE;
                            end
                        end
                    end
                    ST_MODE: begin
                        // the first two of the 2+4 dummy clocks carry the mode byte
                        if (sclk_rise) begin
                            mode_q <= {mode_q[3:0], io_s};
                            shift_q <= {shift_q[19:0], io_s};
                            cnt_q <= cnt_q + 5'h01;
                            if (cnt_q == `MODE_CYCLES - 5'h01) begin
                                cnt_q <= 5'h00;
                                state_q <= ST_DUMMY;
                                o_rd_addr <= shift_q[ADDR_BITS+3:4];
                            end
                        end
                    end
                    ST_DUMMY: begin
                        if (sclk_rise) begin
                            cnt_q <= cnt_q + 5'h01;
                            if (cnt_q == 5'h00) begin
                                // only this quad read path sets enhance mode
                                o_enhance_mode <= mode_toggles;
                            end
                            if (cnt_q == `DUMMY_CYCLES - 5'h01) begin
                                state_q <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: begin
                        // nibbles leave on falling clock, high half first
                        if (sclk_fall) begin
                            o_io_lines_oe_n <= 4'h0;
                            nib_hi_q <= ~nib_hi_q;
                            if (nib_hi_q) begin
                                o_io_lines <= i_rd_data[7:4];
                            end else begin
                                o_io_lines <= i_rd_data[3:0];
                                o_rd_addr <= addr_next;
                            end
                        end
                    end
                    ST_SERIAL: begin
                        // single-line address or wrap code, counted to check the boundary
                        if (sclk_rise) begin
                            shift_q <= {shift_q[22:0], io_s[0]};
                            if (cnt_q != 5'h1f) begin
                                cnt_q <= cnt_q + 5'h01;
                            end
                        end
                    end
                    ST_IGNORE: begin
                        if (sclk_rise && cnt_q != 5'h1f) begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

/* dv/qflash_cmd_asserts.sv */
// checker for the quad read / wrap / sector clear command block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
`include "qflash_defs.vh"
module qflash_cmd_asserts #(
    parameter ADDR_BITS = 20,
    parameter CLEAR_CYCLES = 125000
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_chip_select_n,
    input wire logic i_serial_clock,
    input wire logic [3:0] i_io_lines,
    input wire logic [3:0] o_io_lines,
    input wire logic [3:0] o_io_lines_oe_n,
    input wire logic i_quad_enable_bit,
    input wire logic [3:0] i_block_protect_bits,
    input wire logic [ADDR_BITS-1:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    input wire logic o_clear_start,
    input wire logic [ADDR_BITS-`SECTOR_LSB-1:0] o_clear_sector,
    input wire logic o_write_in_progress,
    input wire logic o_write_enable_latch,
    input wire logic o_enhance_mode,
    input wire logic o_wrap_enabled
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------
    // helper counters
    // ------------------------------------------------
    logic sclk_q;
    logic [3:0] since_fall_q;
    logic [31:0] since_start_q;
    // saturating count since the last link clock fall, so stale data cannot look fresh
    always_ff @(posedge i_clk) begin
        sclk_q <= i_serial_clock;
        if (i_rst || (sclk_q && !i_serial_clock))
            since_fall_q <= 4'h0;
        else if (since_fall_q != 4'hf)
            since_fall_q <= since_fall_q + 4'h1;
        since_start_q <= o_clear_start ? 32'h0 : since_start_q + 32'h1;
    end
    // top blocks of the array guarded by the protect code
    function automatic bit prot(input int bp, input int blk);
        return bp >= 5 || (bp != 0 && blk >= (1 << (ADDR_BITS - 16)) - (1 << (bp - 1)));
    endfunction
    property p_data_on_fall;
        ($changed(o_io_lines) && o_io_lines_oe_n == 4'h0) |-> since_fall_q <= 4'h6;
    endproperty
    a_data_on_fall: assert property (p_data_on_fall) else $error("data not on fall");
    property p_oe_qe;
        (!i_quad_enable_bit) [*8] |-> o_io_lines_oe_n == 4'hf;
    endproperty
    a_oe_qe: assert property (p_oe_qe) else $error("driven without quad enable");
    property p_oe_busy;
        o_write_in_progress |-> o_io_lines_oe_n == 4'hf;
    endproperty
    a_oe_busy: assert property (p_oe_busy) else $error("read served while busy");
    property p_start_busy;
        o_clear_start |-> o_write_in_progress && o_write_enable_latch;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("erase start state");
    property p_start_on_cs;
        o_clear_start |-> i_chip_select_n && $past(i_chip_select_n, 2);
    endproperty
    a_start_on_cs: assert property (p_start_on_cs) else $error("erase before select");
    property p_wip_len;
        $fell(o_write_in_progress) |-> !o_write_enable_latch &&
            since_start_q + 1 >= CLEAR_CYCLES && since_start_q <= CLEAR_CYCLES + 2;
    endproperty
    a_wip_len: assert property (p_wip_len) else $error("erase length");
    property p_prot;
        o_clear_start |-> !prot(int'(i_block_protect_bits), int'(o_clear_sector) >> 4);
    endproperty
    a_prot: assert property (p_prot) else $error("protected sector erased");
    property p_wrap_reset;
        $fell(i_rst) |-> !o_wrap_enabled && !o_enhance_mode;
    endproperty
    a_wrap_reset: assert property (p_wrap_reset) else $error("state after reset");
endmodule

/* dv/qflash_host.sv */
// host controller model: select, link clock and the four io lines
// assumes the bench merges its lines with the device's enabled outputs
`timescale 1ns/10ps
module qflash_host (
    output logic o_cs_n,
    output logic o_sclk,
    output logic [3:0] o_io,
    input wire logic [3:0] i_io_w
);
    localparam real HALF = 62.5;
    // ------------------------------------------------
    // frame tasks
    // ------------------------------------------------
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_io = 4'h0;
    end
    // off the core grid so link edges never meet a sampling edge
    task automatic start();
        #1.3 o_cs_n = 1'b0;
        #HALF;
    endtask
    // clock idles low; let-go lines show the inverse of the last level
    task automatic stop();
        o_cs_n = 1'b1;
        o_io = ~o_io;
        #(4 * HALF);
    endtask
    // data moves while the clock is low and holds across the rise
    task automatic put(input logic [31:0] v, input int n, input bit quad);
        for (int i = n - 1; i >= 0; i--) begin
            o_io = quad ? v[4 * i +: 4] : {3'h0, v[i]};
            #HALF o_sclk = 1'b1;
            #HALF o_sclk = 1'b0;
        end
    endtask
    // released clocks; nibbles taken at each rise, high nibble first
    task automatic get(input int n, input bit keep, output logic [63:0] d);
        d = '0;
        for (int i = 0; i < n; i++) begin
            o_io = ~o_io;
            #HALF o_sclk = 1'b1;
            if (keep)
                d = {d[59:0], i_io_w};
            #HALF o_sclk = 1'b0;
        end
    endtask
endmodule

/* dv/qflash_cmd_bench.sv */
// testbench for the quad read / wrap / sector clear command block
// assumes a host model on the link and a pattern function as the array
`timescale 1ns/10ps
`include "qflash_defs.vh"
module qflash_cmd_bench;
    localparam int CLR = 2000;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_quad_enable_bit = 1'b1;
    logic [3:0] i_block_protect_bits = 4'h0;
    logic i_chip_select_n, i_serial_clock, o_clear_start, o_write_in_progress;
    logic o_write_enable_latch, o_enhance_mode, o_wrap_enabled, e_exp;
    logic [3:0] h_io, o_io_lines, o_io_lines_oe_n, i_io_lines;
    logic [19:0] o_rd_addr;
    logic [7:0] o_clear_sector, last_sector, i_rd_data;
    logic [7:0] modes [8] = '{8'ha5, 8'hff, 8'h5a, 8'h00, 8'hf0, 8'haa, 8'h0f, 8'h55};
    int checks = 0;
    int n_mismatch = 0;
    int n_clear = 0;
    int n_drive = 0;
    int wrap_w = 0;
    // ------------------------------------------------
    // wiring
    // ------------------------------------------------
    // a line the device lets go shows what the host model leaves there
    assign i_io_lines = (~o_io_lines_oe_n & o_io_lines) | (o_io_lines_oe_n & h_io);
    assign i_rd_data = o_rd_addr[7:0] ^ 8'h3c;
    initial forever #4 i_clk = ~i_clk;
    qflash_host h (.o_cs_n(i_chip_select_n), .o_sclk(i_serial_clock), .o_io(h_io),
        .i_io_w(i_io_lines));
    qflash_cmd #(.ADDR_BITS(20), .CLEAR_CYCLES(CLR)) dut_u (.*);
    // count erase launches and note any driving of the lines
    always @(posedge i_clk) begin
        if (o_clear_start === 1'b1) begin
            n_clear <= n_clear + 1;
            last_sector <= o_clear_sector;
        end
        if (o_io_lines_oe_n !== 4'hf)
            n_drive <= n_drive + 1;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmd(input logic [31:0] v, input int n);
        @(negedge i_clk);
        h.start();
        h.put(v, n, 1'b0);
        h.stop();
    endtask
    // one quad read; ok low means the device must leave the lines alone
    task automatic qread(input logic [19:0] a, input logic [7:0] m, input int nb,
        input bit op, input bit ok);
        logic [63:0] d;
        logic [19:0] e;
        int d0;
        @(negedge i_clk);
        d0 = n_drive;
        h.start();
        if (op)
            h.put(32'(`OP_QUAD_READ), 8, 1'b0);
        h.put(32'(a), 6, 1'b1);
        h.put(32'(m), 2, 1'b1);
        h.get(4, 1'b0, d);
        h.get(2 * nb, 1'b1, d);
        h.stop();
        if (!ok)
            chk("lines released", 0, 32'(n_drive - d0));
        for (int k = 0; ok && k < nb; k++) begin
            e = a + 20'(k);
            if (wrap_w != 0)
                e = (a & ~20'(wrap_w - 1)) | (e & 20'(wrap_w - 1));
            chk("read byte", 32'(e[7:0] ^ 8'h3c), 32'(d[8 * (nb - 1 - k) +: 8]));
        end
    endtask
    // bounded wait for the erase cycle to finish
    task automatic wait_idle();
        for (int n = 0; n < 4 * CLR && o_write_in_progress !== 1'b0; n++)
            @(negedge i_clk);
        if (o_write_in_progress !== 1'b0) begin
            n_mismatch++;
            $display("ERROR erase end expected 0 seen %b", o_write_in_progress);
            print_verdict();
        end
    endtask
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        chk("reset state", 32'hf0, {24'h0, o_io_lines_oe_n, o_wrap_enabled, o_enhance_mode,
            o_write_in_progress, o_write_enable_latch});
        qread(20'hffffe, 8'hff, 4, 1'b1, 1'b1);
        chk("enhance off", 0, 32'(o_enhance_mode));
        e_exp = 1'b0;
        foreach (modes[i]) begin
            qread(20'h00100 + 20'(16 * i), modes[i], 2, !e_exp, 1'b1);
            e_exp = (modes[i][7:4] ^ modes[i][3:0]) == 4'hf;
            chk("enhance state", 32'(e_exp), 32'(o_enhance_mode));
        end
        @(negedge i_clk);
        i_quad_enable_bit = 1'b0;
        qread(20'h00000, 8'hff, 1, 1'b1, 1'b0);
        @(negedge i_clk);
        i_quad_enable_bit = 1'b1;
        $display("test read and enhance done");
        for (int c = 0; c < 5; c++) begin
            cmd({16'h0, `OP_SET_BURST, (c < 4) ? 8'(c) : 8'h12}, 16);
            wrap_w = (c < 4) ? 8 << c : 0;
            chk("wrap enabled", 32'(c < 4), 32'(o_wrap_enabled));
            qread(20'h0103e, 8'hff, 4, 1'b1, 1'b1);
        end
        cmd({16'h0, `OP_SET_BURST, 8'h03}, 16);
        @(negedge i_clk);
        i_rst = 1'b1;
        repeat (3) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        chk("wrap after reset", 0, 32'(o_wrap_enabled));
        $display("test wrap done");
        cmd({24'h0, `OP_WRITE_UNLOCK}, 8);
        chk("write latch", 1, 32'(o_write_enable_latch));
        cmd({`OP_SECTOR_CLEAR, 24'h0a5123}, 32);
        chk("erase count", 1, n_clear);
        chk("erase sector", 32'ha5, 32'(last_sector));
        qread(20'h00000, 8'hff, 1, 1'b1, 1'b0);
        chk("busy", 1, 32'(o_write_in_progress));
        wait_idle();
        chk("latch after erase", 0, 32'(o_write_enable_latch));
        for (int j = 0; j < 4; j++) begin
            if (j > 0)
                cmd({24'h0, `OP_WRITE_UNLOCK}, 8);
            @(negedge i_clk);
            i_block_protect_bits = (j == 3) ? 4'h5 : (j == 2) ? 4'h1 : 4'h0;
            if (j == 1)
                cmd({1'b0, `OP_SECTOR_CLEAR, 23'h052800}, 31);
            else
                cmd({`OP_SECTOR_CLEAR, (j == 3) ? 24'h003000 : 24'h0f3000}, 32);
            chk("no erase", 1, n_clear);
            chk("idle", 0, 32'(o_write_in_progress));
        end
        chk("latch after refusal", 0, 32'(o_write_enable_latch));
        $display("test erase done");
        print_verdict();
    end
endmodule
bind qflash_cmd qflash_cmd_asserts #(.ADDR_BITS(ADDR_BITS), .CLEAR_CYCLES(CLEAR_CYCLES))
    chk_u (.*);
